// File: common/rapc_pkg.sv
// Constants and carrier types for the register preload controller.
// Assumes a single 125 MHz clock; the target device is reached through
// discrete pin controls that an external level shifter turns into voltages.
`default_nettype none

package rapc_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS        = 8;
  // Dwell at the elevated level, in ns (plain default, not printed)
  localparam int DWELL_TIME_NS        = 1000;
  localparam int DWELL_CYCLES         =
    (DWELL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Clock pulse width for capture, high and low, in ns
  localparam int CLK_PULSE_WIDTH_NS   = 10;
  localparam int PULSE_CYCLES         =
    (CLK_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Input setup and hold around the clock edge, in ns
  localparam int INPUT_SETUP_TIME_NS  = 15;
  localparam int INPUT_HOLD_WINDOW_NS = 0;
  localparam int CLK_TO_OUTPUT_NS     = 8;
  // Cycle period without feedback: max(tw high + tw low, setup + hold)
  localparam int PERIOD_NOFB_NS =
    (2 * CLK_PULSE_WIDTH_NS > INPUT_SETUP_TIME_NS + INPUT_HOLD_WINDOW_NS) ?
    2 * CLK_PULSE_WIDTH_NS : INPUT_SETUP_TIME_NS + INPUT_HOLD_WINDOW_NS;
  // Cycle period with feedback: clock-to-output plus setup
  localparam int PERIOD_FB_NS = CLK_TO_OUTPUT_NS + INPUT_SETUP_TIME_NS;
  localparam int SETUP_CYCLES =
    (INPUT_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W      = 16;

  // ==========================================================================
  // Array geometry and fuse map
  localparam int NUM_OUT         = 8;
  localparam int PRODUCT_PITCH   = 40;
  localparam int INPUT_LINES     = 40;
  localparam int ADDR_W          = 12;
  localparam logic MAP_CONNECT   = 1'b0;
  localparam logic MAP_OPEN      = 1'b1;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    RAPC_OP_CLEAR_ALL, RAPC_OP_SET_SEL, RAPC_OP_CAPTURE, RAPC_OP_PROGRAM
  } rapc_op_type;

  typedef struct packed {
    logic [NUM_OUT-1:0] data;     // Pattern or per-output select
    logic [NUM_OUT-1:0] reg_mask; // 1 = registered output
    logic [5:0]         pline;    // Product line for programming
    logic [5:0]         iline;    // Input line for programming
    logic               map_bit;  // Fuse map cell value
    logic               vertical; // Vertical-cell device
  } rapc_req_type;

  typedef struct packed {
    logic               gate_hi;     // Output enable pin raised (disabled)
    logic               clear_elev;  // Elevated level on clear input
    logic               preload_hh;  // Super-high on both preload pins
    logic               clk;         // Device clock pin
    logic [NUM_OUT-1:0] pin_elev;    // Elevated level per output pin
    logic [NUM_OUT-1:0] pin_out;     // Driven level per output pin
    logic [NUM_OUT-1:0] pin_oe;      // Drive enable per output pin
  } rapc_pins_type;

endpackage : rapc_pkg

`default_nettype wire

// File: rtl/rapc_ctrl.sv
// Host-side sequencer that preloads registers of a registered logic array
// and programs its cells. Assumes external drivers turn pin flags into
// elevated or super-high voltages and that the device is powered.
`timescale 1ns/100ps
`default_nettype none

module rapc_ctrl
  import rapc_pkg::*;
(
  // Clock and reset
  input  wire logic          I_MCLK,
  input  wire logic          I_RESET,
  // Request port
  input  wire logic          i_req_valid,
  input  wire rapc_op_type   i_req_op,
  input  wire rapc_req_type  i_req,
  input  wire logic          i_feedback,
  input  wire logic          i_secured,
  output logic               o_req_ready,
  output logic               o_done,
  output logic               o_refused,
  // Derived timing and programming address
  output logic [15:0]        o_min_period_ns,
  output logic [ADDR_W-1:0]  o_cell_addr,
  output logic               o_cell_burn,
  // Device pins
  output rapc_pins_type      o_pins
);

  // ==========================================================================
  // Helpers

  // Array cell address from product and input line
  function automatic logic [ADDR_W-1:0] cell_addr(input logic [5:0] pl,
                                                  input logic [5:0] il);
    cell_addr = ADDR_W'(pl * PRODUCT_PITCH) + ADDR_W'(il);
  endfunction : cell_addr

  // Whether a cell is physically programmed for this technology
  function automatic logic cell_burns(input logic map_bit,
                                      input logic vertical);
    // Zero connects: vertical burns zeroes, fuse burns ones
    cell_burns = vertical ? (map_bit == MAP_CONNECT) :
                            (map_bit == MAP_OPEN);
  endfunction : cell_burns

  // ==========================================================================
  // State and storage
  typedef enum logic [3:0] {
    S_IDLE, S_CLR_HOLD, S_SET_DIS, S_SET_HOLD, S_CAP_DIS, S_CAP_DATA,
    S_CAP_HH, S_CAP_CLKH, S_CAP_CLKL, S_CAP_DROP, S_CAP_EN, S_DONE
  } rapc_state_type;

  rapc_state_type      state;
  rapc_state_type      next_state;
  logic [TIMER_W-1:0]  timer;
  logic                timer_load;
  logic [TIMER_W-1:0]  timer_value;
  rapc_req_type        req;
  rapc_pins_type       next_pins;

  wire logic timer_zero = (timer == '0);

  // ==========================================================================
  // Request acceptance: only idle takes a request
  always_comb begin
    o_req_ready = (state == S_IDLE);
  end

  // Capture request fields on acceptance
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      req <= '0;
    end else if (o_req_ready && i_req_valid) begin
      req <= i_req;
    end
  end

  // ==========================================================================
  // Sequencer
  always_comb begin
    next_state  = state;
    timer_load  = 1'b0;
    timer_value = '0;
    case (state)
      S_IDLE: begin
        if (i_req_valid) begin
          // Preload ops ignore the lockout input
          case (i_req_op)
            RAPC_OP_CLEAR_ALL: begin
              next_state  = S_CLR_HOLD;
              timer_load  = 1'b1;
              timer_value = TIMER_W'(DWELL_CYCLES - 1);
            end
            RAPC_OP_SET_SEL: begin
              next_state  = S_SET_DIS;
              timer_load  = 1'b1;
              timer_value = TIMER_W'(DWELL_CYCLES - 1);
            end
            RAPC_OP_CAPTURE: begin
              // Outputs disabled before any pin data
              next_state  = S_CAP_DIS;
              timer_load  = 1'b1;
              timer_value = TIMER_W'(SETUP_CYCLES - 1);
            end
            default: begin
              // Programming is a single strobe; lockout handled below
              next_state = S_DONE;
            end
          endcase
        end
      end
      S_CLR_HOLD: begin
        if (timer_zero) begin
          next_state = S_DONE;
        end
      end
      S_SET_DIS: begin
        if (timer_zero) begin
          next_state  = S_SET_HOLD;
          timer_load  = 1'b1;
          timer_value = TIMER_W'(DWELL_CYCLES - 1);
        end
      end
      S_SET_HOLD: begin
        if (timer_zero) begin
          next_state = S_DONE;
        end
      end
      S_CAP_DIS: begin
        if (timer_zero) begin
          next_state  = S_CAP_DATA;
          timer_load  = 1'b1;
          timer_value = TIMER_W'(SETUP_CYCLES - 1);
        end
      end
      S_CAP_DATA: begin
        if (timer_zero) begin
          next_state  = S_CAP_HH;
          timer_load  = 1'b1;
          timer_value = TIMER_W'(SETUP_CYCLES - 1);
        end
      end
      S_CAP_HH: begin
        if (timer_zero) begin
          next_state  = S_CAP_CLKH;
          timer_load  = 1'b1;
          timer_value = TIMER_W'(PULSE_CYCLES - 1);
        end
      end
      S_CAP_CLKH: begin
        if (timer_zero) begin
          next_state  = S_CAP_CLKL;
          timer_load  = 1'b1;
          timer_value = TIMER_W'(PULSE_CYCLES - 1);
        end
      end
      S_CAP_CLKL: begin
        if (timer_zero) begin
          next_state  = S_CAP_DROP;
          timer_load  = 1'b1;
          timer_value = TIMER_W'(SETUP_CYCLES - 1);
        end
      end
      S_CAP_DROP: begin
        if (timer_zero) begin
          next_state = S_CAP_EN;
        end
      end
      S_CAP_EN: begin
        next_state = S_DONE;
      end
      S_DONE: begin
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Dwell and pulse timer; counts down to zero
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      timer <= '0;
    end else if (timer_load) begin
      timer <= timer_value;
    end else if (!timer_zero) begin
      timer <= timer - 1'b1;
    end
  end

  // ==========================================================================
  // Pin drive per state
  always_comb begin
    next_pins = '0;
    case (next_state)
      S_CLR_HOLD: begin
        next_pins.clear_elev = 1'b1;
      end
      S_SET_DIS: begin
        next_pins.gate_hi = 1'b1;
      end
      S_SET_HOLD: begin
        next_pins.gate_hi  = 1'b1;
        next_pins.pin_elev = req.data & req.reg_mask;
      end
      S_CAP_DIS: begin
        next_pins.gate_hi = 1'b1;
      end
      S_CAP_DATA, S_CAP_HH, S_CAP_CLKH, S_CAP_CLKL, S_CAP_DROP: begin
        next_pins.gate_hi = 1'b1;
        next_pins.pin_oe  = '1;
        next_pins.pin_out = req.data & req.reg_mask;
        // Super-high held across the clock pulse
        next_pins.preload_hh = (next_state == S_CAP_HH) ||
                               (next_state == S_CAP_CLKH) ||
                               (next_state == S_CAP_CLKL);
        // Rising device clock captures pin data
        next_pins.clk = (next_state == S_CAP_CLKH);
      end
      default: begin
        // Super-high gone; enable low restores outputs
        next_pins = '0;
      end
    endcase
  end

  // Registered pin drive
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      o_pins <= '0;
    end else begin
      o_pins <= next_pins;
    end
  end

  // ==========================================================================
  // Programming strobe and lockout refusal; both set on the take edge so
  // they stand in the same cycle as the done pulse of a program op
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      o_cell_addr <= '0;
      o_cell_burn <= 1'b0;
      o_refused   <= 1'b0;
    end else begin
      o_cell_burn <= 1'b0;
      o_refused   <= 1'b0;
      if (o_req_ready && i_req_valid && i_req_op == RAPC_OP_PROGRAM) begin
        o_cell_addr <= cell_addr(i_req.pline, i_req.iline);
        if (i_secured) begin
          o_refused <= 1'b1;
        end else begin
          o_cell_burn <= cell_burns(i_req.map_bit, i_req.vertical);
        end
      end
    end
  end

  // Completion pulse, one cycle while the done state stands
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      o_done <= 1'b0;
    end else begin
      o_done <= (next_state == S_DONE);
    end
  end

  // ==========================================================================
  // Minimum device clock period, chosen by feedback use
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      o_min_period_ns <= '0;
    end else if (i_feedback) begin
      o_min_period_ns <= 16'(PERIOD_FB_NS);
    end else begin
      o_min_period_ns <= 16'(PERIOD_NOFB_NS);
    end
  end

  // Array updates suppressed: pins never clock the device while preload
  // pins are raised except the one capture pulse.
  // No other clock during preload

endmodule : rapc_ctrl

`default_nettype wire

// File: sim/rapc_chk.sv
// Port checker for the preload controller, bound to its top module.
// Assumes the bench holds i_req and i_secured steady through an operation.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Checker
module rapc_chk
  import rapc_pkg::*;
(
  // Clock, reset and request side
  input wire logic          I_MCLK,
  input wire logic          I_RESET,
  input wire rapc_req_type  i_req,
  input wire logic          i_feedback,
  input wire logic          i_secured,
  // Status and pins
  input wire logic          o_req_ready,
  input wire logic          o_done,
  input wire logic          o_refused,
  input wire logic          o_cell_burn,
  input wire logic [15:0]   o_min_period_ns,
  input wire rapc_pins_type o_pins
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);

  // Status pulses
  a_refuse_done: assert property (o_refused |-> o_done)
    else $error("refused without done");
  a_locked_noburn: assert property (o_cell_burn |-> !i_secured)
    else $error("burn on locked device");
  a_done_ready: assert property (o_done |=> !o_done && o_req_ready)
    else $error("done not a pulse or not idle after");
  // Period figures, one cycle behind a steady selector
  a_period_nofb: assert property (
    !i_feedback && $stable(i_feedback)
    |=> o_min_period_ns == 16'(PERIOD_NOFB_NS))
    else $error("period without feedback wrong");
  a_period_fb: assert property (
    i_feedback && $stable(i_feedback)
    |=> o_min_period_ns == 16'(PERIOD_FB_NS))
    else $error("period with feedback wrong");
  // Capture sequence
  a_clk_gated: assert property (
    $rose(o_pins.clk) |-> o_pins.preload_hh && o_pins.gate_hi)
    else $error("clock pulse outside preload");
  a_clk_width: assert property (
    $rose(o_pins.clk) |-> o_pins.clk [*2] ##1 !o_pins.clk)
    else $error("clock pulse width wrong");
  a_gate_first: assert property (
    $rose(|o_pins.pin_oe) |-> $past(o_pins.gate_hi))
    else $error("pin data before outputs disabled");
  a_unreg_low: assert property (
    o_pins.preload_hh |-> (o_pins.pin_out & ~i_req.reg_mask) == '0)
    else $error("non-registered pin not low");
  a_hh_before_gate: assert property (
    $fell(o_pins.gate_hi) |-> !o_pins.preload_hh)
    else $error("enable lowered under super-high");
  // Elevated-level preloads
  a_clear_dwell: assert property (
    $rose(o_pins.clear_elev) |-> ##124 o_pins.clear_elev)
    else $error("clear level shorter than dwell");
  a_set_wait: assert property (
    $rose(|o_pins.pin_elev) |-> $past(o_pins.gate_hi, 125))
    else $error("set level without dwell after disable");
  a_async_noclk: assert property (
    (o_pins.clear_elev || |o_pins.pin_elev) |-> !o_pins.clk)
    else $error("clock during asynchronous preload");
endmodule : rapc_chk

bind rapc_ctrl rapc_chk rapc_chk_inst (.I_MCLK, .I_RESET, .i_req,
  .i_feedback, .i_secured, .o_req_ready, .o_done, .o_refused,
  .o_cell_burn, .o_min_period_ns, .o_pins);
`default_nettype wire

// File: sim/rapc_dev.sv
// Behavioural model of the registered array as seen through preload.
// Assumes pin flags stand for the real voltages; no array logic modelled.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Device model
module rapc_dev
  import rapc_pkg::*;
(
  // Pins from the controller
  input  wire rapc_pins_type i_pins,
  // Register contents for the bench
  output logic [NUM_OUT-1:0] o_state
);
  logic [NUM_OUT-1:0] sel;

  initial o_state = '0;

  // Clear only after a full dwell
  always @(posedge i_pins.clear_elev) begin
    #(DWELL_TIME_NS - 1);
    if (i_pins.clear_elev) o_state = '0;
  end

  always @(i_pins.pin_elev) begin
    sel = i_pins.pin_elev;
    #(DWELL_TIME_NS - 1);
    if (i_pins.gate_hi && (i_pins.pin_elev & sel) == sel)
      o_state = o_state | sel;
  end

  // Capture pin data under super-high
  // Undriven pins read low, so a missing enable loses the bit
  always @(posedge i_pins.clk) begin
    if (i_pins.preload_hh && i_pins.gate_hi)
      o_state = i_pins.pin_out & i_pins.pin_oe;
  end
endmodule : rapc_dev
`default_nettype wire

// File: sim/rapc_ctrl_bench.sv
// Self-checking bench for the preload controller and a device model.
// Assumes the package timing constants as shipped.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Bench
module rapc_ctrl_bench;
  import rapc_pkg::*;
  logic              I_MCLK;
  logic              I_RESET;
  logic              req_valid;
  rapc_op_type       req_op;
  rapc_req_type      req;
  logic              feedback;
  logic              secured;
  logic              ready;
  logic              done;
  logic              refused;
  logic              burn;
  logic              burn_seen;
  logic [15:0]       period;
  logic [ADDR_W-1:0] addr;
  rapc_pins_type     pins;
  logic [NUM_OUT-1:0] state;
  int                errors;
  int                n_checks;
  int                lat;

  // Clock
  always #(CLK_PERIOD_NS / 2) I_MCLK = ~I_MCLK;

  rapc_ctrl rapc_ctrl_inst (.I_MCLK, .I_RESET, .i_req_valid(req_valid),
    .i_req_op(req_op), .i_req(req), .i_feedback(feedback),
    .i_secured(secured), .o_req_ready(ready), .o_done(done),
    .o_refused(refused), .o_min_period_ns(period), .o_cell_addr(addr),
    .o_cell_burn(burn), .o_pins(pins));
  rapc_dev rapc_dev_inst (.i_pins(pins), .o_state(state));

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  // One operation; called at a falling edge, returns at the done edge
  task automatic run_op(input rapc_op_type op, input rapc_req_type r);
    // Let the previous done cycle pass; a request then would be lost
    while (ready !== 1'b1) begin
      @(negedge I_MCLK);
    end
    req_op = op;
    req = r;
    req_valid = 1'b1;
    @(posedge I_MCLK);
    @(negedge I_MCLK);
    req_valid = 1'b0;
    lat = 0;
    // Burn pulse already stands in the cycle after the take
    burn_seen = burn;
    while (done !== 1'b1 && lat < 400) begin
      @(posedge I_MCLK);
      @(negedge I_MCLK);
      lat++;
      burn_seen = burn_seen | burn;
    end
    chk("done", 16'd1, 16'(done));
  endtask : run_op

  task automatic t_capture(input logic [7:0] d, input logic [7:0] m,
                           input logic s);
    rapc_req_type r;
    r = '0;
    r.data = d;
    r.reg_mask = m;
    secured = s;
    run_op(RAPC_OP_CAPTURE, r);
    chk("refused", 16'd0, 16'(refused));
    chk("state", 16'(d & m), 16'(state));
    $display("capture %h mask %h finished", d, m);
  endtask : t_capture

  task automatic t_async();
    rapc_req_type r;
    r = '0;
    secured = 1'b1;
    run_op(RAPC_OP_CLEAR_ALL, r);
    chk("clear latency", 16'(DWELL_CYCLES), 16'(lat));
    chk("state", 16'h0000, 16'(state));
    r.data = 8'h81;
    r.reg_mask = 8'hff;
    run_op(RAPC_OP_SET_SEL, r);
    chk("set latency", 16'(2 * DWELL_CYCLES), 16'(lat));
    chk("state", 16'h0081, 16'(state));
    $display("clear and set finished");
  endtask : t_async

  task automatic t_prog();
    rapc_req_type r;
    r = '0;
    secured = 1'b0;
    for (int k = 0; k < 4; k++) begin
      r.vertical = k[1];
      r.map_bit = k[0];
      r.pline = 6'(k + 1);
      r.iline = 6'd39;
      run_op(RAPC_OP_PROGRAM, r);
      chk("burn", 16'(k[1] ^ k[0]), 16'(burn_seen));
      chk("addr", 16'((k + 1) * PRODUCT_PITCH + 39), 16'(addr));
    end
    r.map_bit = MAP_CONNECT;
    secured = 1'b1;
    run_op(RAPC_OP_PROGRAM, r);
    chk("refused", 16'd1, 16'(refused));
    chk("locked burn", 16'd0, 16'(burn_seen));
    $display("program finished");
  endtask : t_prog

  task automatic t_period();
    feedback = 1'b0;
    repeat (2) @(negedge I_MCLK);
    chk("period", 16'(PERIOD_NOFB_NS), period);
    feedback = 1'b1;
    repeat (2) @(negedge I_MCLK);
    chk("period", 16'(PERIOD_FB_NS), period);
    $display("period finished");
  endtask : t_period

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(CLK_PERIOD_NS * 20000);
    errors++;
    close_out();
  end

  // Main sequence
  initial begin
    I_MCLK = 1'b0;
    I_RESET = 1'b1;
    req_valid = 1'b0;
    req_op = RAPC_OP_CLEAR_ALL;
    req = '0;
    feedback = 1'b0;
    secured = 1'b0;
    errors = 0;
    n_checks = 0;
    repeat (4) @(posedge I_MCLK);
    @(negedge I_MCLK);
    I_RESET = 1'b0;
    t_capture(8'ha5, 8'hff, 1'b0);
    t_capture(8'hff, 8'h0f, 1'b1);
    t_async();
    t_prog();
    t_period();
    close_out();
  end
endmodule : rapc_ctrl_bench
`default_nettype wire
